// [dv/dcb_decoder_sva.sv]
// Assertions for the configuration bit decoder
`timescale 1ns/1ns
`default_nettype none
module dcb_decoder_chk import dcb_pkg::*; (
    input wire logic        ref_clk, rst_n, cfg_valid, sw_watchdog_enable, startup_target_ready,
    input wire logic [19:0] cfg_word,
    input wire dcb_ctrl_s   ctrl,
    input wire logic        cfg_loaded, on_fast_rc_startup, watchdog_run, low_power_rc_run);
    logic [19:0] w;
    // Shadow of the word the decoder should have latched
    always_ff @(posedge ref_clk) if (!rst_n) w <= cfg_valid ? cfg_word : 20'hfffff;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    prot_bits_a: assert property (ctrl.readout_protect == !w[0] && ctrl.write_protect == !w[1])
        else $error("protect decode");
    osc_sel_a: assert property (ctrl.initial_osc_select == w[6:4] && ctrl.osc_select_reserved == (w[6:4] == 3'h4))
        else $error("osc select decode");
    clk_mon_a: assert property (ctrl.clk_switch_en == !w[8] && ctrl.fail_safe_monitor_en == (w[8:7] == 2'h0))
        else $error("switch mode decode");
    pin_out_a: assert property (ctrl.primary_osc_mode == w[12:11] && ctrl.primary_osc_en == (w[12:11] != 2'h3)
        && ctrl.secondary_osc_clk_out == (w[10] && !(w[12:11] inside {2'h1, 2'h2}))) else $error("pin decode");
    misc_bits_a: assert property (ctrl.pwm_key_lock_en == w[3] && ctrl.pin_remap_single_shot == w[9]
        && ctrl.watchdog_window_mode == !w[14] && ctrl.pll_lock_wait_en == w[15] && ctrl.two_speed_startup_en == w[2])
        else $error("misc decode");
    wdog_run_a: assert property (watchdog_run == (w[13] | sw_watchdog_enable) && low_power_rc_run == watchdog_run)
        else $error("watchdog run");
    debug_pull_a: assert property (ctrl.tms_pullup_en == w[16] && ctrl.debug_port_en == w[16])
        else $error("debug pull-up");
    hold_cfg_a: assert property ($past(rst_n) |-> $stable(ctrl) && $stable(cfg_loaded))
        else $error("settings moved");
    start_fast_a: assert property ($rose(startup_target_ready) |-> ##3 !on_fast_rc_startup)
        else $error("startup switch");
endmodule // dcb_decoder_chk
bind dcb_decoder dcb_decoder_chk u_chk (.*);
`default_nettype wire

// [dv/test_dcb_decoder.sv]
// Self-checking bench for the configuration bit decoder
`timescale 1ns/1ns
`default_nettype none
module test_dcb_decoder;
    logic ref_clk = 0, rst_n = 0, cfg_valid = 1, sw_watchdog_enable = 0, startup_target_ready = 0;
    logic [19:0] cfg_word = 20'h00000;
    dcb_pkg::dcb_ctrl_s ctrl;
    logic cfg_loaded, on_fast_rc_startup, watchdog_run, low_power_rc_run;
    int err_total = 0, tests_run = 0;
    // Expected {readout_protect, monitor, clock out} above each word
    // No row programs the reserved oscillator code
    logic [22:0] rows [4] = '{23'h600000, 23'h1fffff, 23'h000ca1, 23'h500530};
    always #5 ref_clk = ~ref_clk;
    dcb_decoder u_dut (.*);
    task chk(input logic [2:0] s, input logic [2:0] e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %0t got %b expected %b", $time, s, e);
        end
    endtask
    task load(input logic [19:0] w, input logic v);
        rst_n <= 0;
        cfg_word <= w;
        cfg_valid <= v;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1;
        @(posedge ref_clk);
        #1;
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        foreach (rows[i]) begin
            @(posedge ref_clk) load(rows[i][19:0], 1);
            chk({ctrl.readout_protect, ctrl.fail_safe_monitor_en, ctrl.secondary_osc_clk_out}, rows[i][22:20]);
        end
        @(posedge ref_clk) load(20'h02000, 0);
        chk({cfg_loaded, ctrl.debug_port_en, ctrl.watchdog_forced_on}, 3'h3);
        @(posedge ref_clk) cfg_word <= 20'h00000;
        repeat (2) @(posedge ref_clk);
        #1;
        chk({ctrl.debug_port_en, watchdog_run, low_power_rc_run}, 3'h7);
        @(posedge ref_clk) load(20'h00004, 1);
        chk({on_fast_rc_startup, watchdog_run, cfg_loaded}, 3'h5);
        @(posedge ref_clk) sw_watchdog_enable <= 1;
        startup_target_ready <= 1;
        // Ready passes two synchroniser stages before the start-up flag drops
        repeat (3) @(posedge ref_clk);
        #1;
        chk({on_fast_rc_startup, watchdog_run, low_power_rc_run}, 3'h3);
        print_verdict;
    end
    // Whole run is under 100 cycles; this margin only catches a hang
    initial begin
        #5000;
        err_total++;
        print_verdict;
    end
endmodule // test_dcb_decoder
`default_nettype wire

// [rtl/dcb_cfg.svh]
// Configuration word field positions and reset values for the configuration bit decoder
// Summary of operation
// - Code-protect bit 0 protects all program memory against readout; 1 leaves it open.
// - Write-protect bit 0 blocks program memory writes; 1 allows them.
// - Two-speed start bit 1 starts on fast RC, then switches when source ready.
// - PWM lock bit 1 requires a key sequence before PWM register writes.
// - Oscillator select field picks one of seven clock sources by its code.
// - Switch mode 1x disables switching and monitor; 01 switching only; 00 both.
// - Pin remap bit 1 allows one remap only; 0 allows many.
// - Outside crystal modes, pin bit 1 drives clock out on secondary pin.
// - Primary mode field: 11 off, 10 high-speed crystal, 01 crystal, 00 external.
// - Watchdog forced bit 1 keeps watchdog and low-power RC always running.
// - Watchdog forced bit 0 lets software enable control watchdog and low-power RC.
// - Window disable bit 0 selects window mode; 1 selects non-window mode.
// - PLL lock bit 1 enables lock qualification; 0 disables it.
// - Debug port enable 1 turns on a pull-up on test mode select.
// - Erased device reads debug port enable as 1.
`ifndef DCB_CFG_SVH
`define DCB_CFG_SVH
`define DCB_CFG_W             20
`define DCB_POS_CODE_PROT_N   0
`define DCB_POS_WRITE_PROT_N  1
`define DCB_POS_TWO_SPEED     2
`define DCB_POS_PWM_LOCK      3
`define DCB_POS_OSC_SEL       4
`define DCB_W_OSC_SEL         3
`define DCB_POS_SWITCH_MODE   7
`define DCB_W_SWITCH_MODE     2
`define DCB_POS_REMAP_ONCE    9
`define DCB_POS_OSC_PIN_FN    10
`define DCB_POS_PRI_MODE      11
`define DCB_W_PRI_MODE        2
`define DCB_POS_WDOG_FORCED   13
`define DCB_POS_WIN_DISABLE   14
`define DCB_POS_PLL_LOCK      15
`define DCB_POS_DEBUG_EN      16
`define DCB_ERASED_WORD       20'hfffff
`endif

// [rtl/dcb_decoder.sv]
// Configuration bit decoder: captures the nonvolatile word during reset and drives chip controls
`timescale 1ns/1ns
`default_nettype none
`include "dcb_cfg.svh"

module dcb_decoder
    import dcb_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic [`DCB_CFG_W-1:0] cfg_word,
    input  wire logic                  cfg_valid,
    input  wire logic                  sw_watchdog_enable,
    input  wire logic                  startup_target_ready,
    output var  dcb_ctrl_s             ctrl,
    output var  logic                  cfg_loaded,
    output var  logic                  on_fast_rc_startup,
    output var  logic                  watchdog_run,
    output var  logic                  low_power_rc_run
);

    logic [`DCB_CFG_W-1:0] next_word;
    dcb_ctrl_s             next_ctrl;
    logic                  ready_meta;
    logic                  ready_sync;
    logic                  startup_done;

    // Word to capture: memory contents, or the erased pattern when memory has nothing
    function automatic logic [`DCB_CFG_W-1:0] source_word(
        input logic                  valid,
        input logic [`DCB_CFG_W-1:0] mem_word
    );
        logic [`DCB_CFG_W-1:0] result;
        if (valid) begin
            result = mem_word;
        end else begin
            result = `DCB_ERASED_WORD;
        end
        return result;
    endfunction

    // Protect bits are stored active low so an erased part stays open
    function automatic logic readout_protected(
        input logic [`DCB_CFG_W-1:0] word
    );
        return ~word[`DCB_POS_CODE_PROT_N];
    endfunction

    function automatic logic writes_blocked(
        input logic [`DCB_CFG_W-1:0] word
    );
        return ~word[`DCB_POS_WRITE_PROT_N];
    endfunction

    function automatic dcb_osc_e osc_code(
        input logic [`DCB_CFG_W-1:0] word
    );
        return dcb_osc_e'(word[`DCB_POS_OSC_SEL +: `DCB_W_OSC_SEL]);
    endfunction

    function automatic logic [`DCB_W_SWITCH_MODE-1:0] switch_code(
        input logic [`DCB_CFG_W-1:0] word
    );
        return word[`DCB_POS_SWITCH_MODE +: `DCB_W_SWITCH_MODE];
    endfunction

    // Upper bit set turns both switching and the monitor off, whatever the lower bit
    function automatic logic switching_allowed(
        input logic [`DCB_W_SWITCH_MODE-1:0] mode
    );
        return ~mode[1];
    endfunction

    function automatic logic monitor_allowed(
        input logic [`DCB_W_SWITCH_MODE-1:0] mode
    );
        return (mode == 2'h0);
    endfunction

    function automatic dcb_pri_e pri_code(
        input logic [`DCB_CFG_W-1:0] word
    );
        return dcb_pri_e'(word[`DCB_POS_PRI_MODE +: `DCB_W_PRI_MODE]);
    endfunction

    function automatic logic is_crystal_mode(
        input dcb_pri_e mode
    );
        return (mode == DCB_PRI_STD_XTAL) || (mode == DCB_PRI_FAST_XTAL);
    endfunction

    // Shared by the watchdog and its low-power clock: one may not stop while the other runs
    function automatic logic watchdog_clock_needed(
        input logic forced_on,
        input logic sw_enable
    );
        return forced_on | sw_enable;
    endfunction

    function automatic dcb_ctrl_s decode_word(
        input logic [`DCB_CFG_W-1:0] word
    );
        dcb_ctrl_s                    result;
        logic [`DCB_W_SWITCH_MODE-1:0] mode;
        mode                         = switch_code(word);
        result.readout_protect       = readout_protected(word);
        result.write_protect         = writes_blocked(word);
        result.two_speed_startup_en  = word[`DCB_POS_TWO_SPEED];
        result.pwm_key_lock_en       = word[`DCB_POS_PWM_LOCK];
        result.initial_osc_select    = osc_code(word);
        // Reserved code is passed through but flagged for the clock logic to see
        result.osc_select_reserved   = (osc_code(word) == DCB_OSC_RSVD);
        result.clk_switch_en         = switching_allowed(mode);
        result.fail_safe_monitor_en  = monitor_allowed(mode);
        result.pin_remap_single_shot = word[`DCB_POS_REMAP_ONCE];
        result.primary_osc_mode      = pri_code(word);
        result.primary_osc_en        = (pri_code(word) != DCB_PRI_OFF);
        // Crystal modes own the secondary pin, so the function bit is ignored there
        result.secondary_osc_clk_out = word[`DCB_POS_OSC_PIN_FN]
                                       && !is_crystal_mode(pri_code(word));
        result.watchdog_forced_on    = word[`DCB_POS_WDOG_FORCED];
        result.watchdog_window_mode  = ~word[`DCB_POS_WIN_DISABLE];
        result.pll_lock_wait_en      = word[`DCB_POS_PLL_LOCK];
        result.debug_port_en         = word[`DCB_POS_DEBUG_EN];
        result.tms_pullup_en         = word[`DCB_POS_DEBUG_EN];
        return result;
    endfunction

    assign next_word = source_word(cfg_valid, cfg_word);
    assign next_ctrl = decode_word(next_word);

    // Settings are decoded on the way in, so ctrl and cfg_loaded come straight from flip-flops.
    // Outside reset nothing reloads them: a memory glitch in mission mode cannot reach the chip.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl <= next_ctrl;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_loaded <= cfg_valid;
        end
    end

    // The ready flag comes from the oscillator's own clock, so it is synchronised first.
    // This delays the hand-over to the chosen source by two clocks, which is harmless.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ready_meta <= 1'b0;
            ready_sync <= 1'b0;
        end else begin
            ready_meta <= startup_target_ready;
            ready_sync <= ready_meta;
        end
    end

    // Two-speed start: sit on fast RC until the chosen source reports ready
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            startup_done <= 1'b0;
        end else if (ready_sync) begin
            startup_done <= 1'b1;
        end
    end

    assign on_fast_rc_startup = ctrl.two_speed_startup_en && !startup_done;

    // With the forced bit set, clearing the software enable has no effect
    assign watchdog_run       = watchdog_clock_needed(ctrl.watchdog_forced_on,
                                                      sw_watchdog_enable);
    assign low_power_rc_run   = watchdog_clock_needed(ctrl.watchdog_forced_on,
                                                      sw_watchdog_enable);

endmodule // dcb_decoder
`default_nettype wire

// [rtl/dcb_pkg.sv]
// Types for the configuration bit decoder
`default_nettype none
package dcb_pkg;
    typedef enum logic [2:0] {
        DCB_OSC_FAST_RC = 3'h0, DCB_OSC_FAST_RC_DIV_N_PLL = 3'h1, DCB_OSC_PRI = 3'h2, DCB_OSC_PRI_PLL = 3'h3,
        DCB_OSC_RSVD = 3'h4, DCB_OSC_LOW_POWER_RC = 3'h5, DCB_OSC_FAST_RC_DIV_16 = 3'h6,
        DCB_OSC_FAST_RC_DIV_N = 3'h7
    } dcb_osc_e;
    typedef enum logic [1:0] {
        DCB_PRI_EXT_CLK = 2'h0, DCB_PRI_STD_XTAL = 2'h1, DCB_PRI_FAST_XTAL = 2'h2, DCB_PRI_OFF = 2'h3
    } dcb_pri_e;
    typedef struct packed {
        logic     readout_protect;
        logic     write_protect;
        logic     two_speed_startup_en;
        logic     pwm_key_lock_en;
        dcb_osc_e initial_osc_select;
        logic     osc_select_reserved;
        logic     clk_switch_en;
        logic     fail_safe_monitor_en;
        logic     pin_remap_single_shot;
        dcb_pri_e primary_osc_mode;
        logic     primary_osc_en;
        logic     secondary_osc_clk_out;
        logic     watchdog_forced_on;
        logic     watchdog_window_mode;
        logic     pll_lock_wait_en;
        logic     debug_port_en;
        logic     tms_pullup_en;
    } dcb_ctrl_s;
endpackage
`default_nettype wire
